// >>> accel_regs_defs.svh
// offsets, field positions, reset values and timing counts of the register bank
// assumes a 250 MHz mclk and a byte-wide register access port
`ifndef ACCEL_REGS_DEFS_SVH
`define ACCEL_REGS_DEFS_SVH
// ==========================================================
// register offsets
`define OFS_Y_LO      8'h08
`define OFS_Y_HI      8'h09
`define OFS_Z_LO      8'h0A
`define OFS_Z_HI      8'h0B
`define OFS_CHECK     8'h0C
`define OFS_IDENT     8'h0F
`define OFS_CAUSE     8'h16
`define OFS_DIR       8'h17
`define OFS_SUMMARY   8'h18
`define OFS_RELEASE   8'h1A
`define OFS_MAINCTL   8'h1B
// ==========================================================
// reset and fixed values
`define CHECK_IDLE    8'h55
`define CHECK_ARMED   8'hAA
`define MAINCTL_RST   8'h00
// ==========================================================
// field positions
`define B_OPMODE      7
`define B_PREC        6
`define B_DRIRQ       5
`define B_RANGE_HI    4
`define B_RANGE_LO    3
`define B_MOTION      1
`define B_CAUSE_SAMPLE_READY_FLAG  4
`define B_CAUSE_MOT   1
`define B_SUMMARY     4
`define B_SELFTEST    4
// ==========================================================
// timing
`define CLK_PERIOD_NS 4
`define IRQ_PULSE_NS  30000
`define IRQ_PULSE_CYC ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> accel_regs_pkg.sv
// types shared by the register bank and its sample holder
// no assumptions beyond a SystemVerilog package scope
package accel_regs_pkg;
  // ==========================================================
  // main control fields
  typedef struct packed {
    logic       op_mode;
    logic       precision;
    logic       ready_irq_en;
    logic [1:0] range_sel;
    logic       motion_en;
  } main_ctrl_t;

  typedef struct packed {
    logic [13:0] y;
    logic [13:0] z;
  } sample_pair_t;

  typedef enum logic [1:0] {IRQ_IDLE, IRQ_PULSE, IRQ_HELD} irq_state_t;
endpackage

// >>> sample_hold.sv
// double-buffered Y/Z sample store with read protection
// assumes busy is high for the whole host read transaction
`timescale 1ns/1ns
module sample_hold (
  input  wire logic                         mclk,
  input  wire logic                         sys_rst,
  input  wire logic                         load,
  input  wire accel_regs_pkg::sample_pair_t sample,
  input  wire logic                         busy,
  output accel_regs_pkg::sample_pair_t      held_r,
  output logic                              fresh_r
);
  // ==========================================================
  // pending slot
  accel_regs_pkg::sample_pair_t pend_r;
  logic                         pend_valid_r;
  logic                         commit;

  // a sample arriving mid-read waits so the host never sees mixed bytes
  assign commit = !busy && (load || pend_valid_r);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r       <= '0;
      pend_valid_r <= 1'b0;
    end else if (load) begin
      pend_r       <= sample;
      pend_valid_r <= busy;
    end else if (commit) begin
      pend_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      held_r  <= '0;
      fresh_r <= 1'b0;
    end else begin
      fresh_r <= commit;
      if (commit) begin
        held_r <= load ? sample : pend_r;
      end
    end
  end
endmodule // sample_hold

// >>> accel_output_interrupt_regs.sv
// Y/Z outputs, self-test response, identity, interrupt and main control registers
// assumes a byte register port driven by the device's serial target engine
`timescale 1ns/1ns
`include "accel_regs_defs.svh"
module accel_output_interrupt_regs #(
  parameter int         PULSE_CYC  = `IRQ_PULSE_CYC,
  parameter logic [7:0] IDENT_CODE = 8'hA7 // arbitrary value
) (
  input  wire logic                         mclk,
  input  wire logic                         sys_rst,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_busy,
  output logic [7:0]                        reg_rdata,
  input  wire logic                         sample_valid,
  input  wire accel_regs_pkg::sample_pair_t sample,
  input  wire logic                         motion_event,
  input  wire logic [5:0]                   motion_dir,
  input  wire logic                         selftest_req,
  input  wire logic                         irq_pulse_select,
  output logic                              selftest_done,
  output logic                              irq_out,
  output accel_regs_pkg::main_ctrl_t        ctrl,
  output logic                              wide_mode
);
  // ==========================================================
  // declarations
  accel_regs_pkg::main_ctrl_t   ctrl_r;
  accel_regs_pkg::sample_pair_t held;
  accel_regs_pkg::irq_state_t   irq_state_r;
  logic        fresh;
  logic        ready_r, motion_r, summary_r, armed_r, req_q_r, done_r;
  logic [5:0]  dir_r;
  logic [7:0]  rdata_r, rd_mux;
  logic [31:0] pulse_cnt_r;
  logic        data_rd, rel_rd, check_rd, ready_set, motion_set;

  // ==========================================================
  // output formatting
  function automatic logic [7:0] fmt_lo(input logic [13:0] s, input logic p,
                                         input logic w);
    if (w)
      fmt_lo = {s[5:0], 2'h0};
    else if (p)
      fmt_lo = {s[5:2], 4'h0};
    else
      fmt_lo = 8'h00;
  endfunction

  function automatic logic [7:0] fmt_hi(input logic [13:0] s);
    fmt_hi = s[13:6];
  endfunction

  // ==========================================================
  // sample store
  sample_hold u_hold (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .load    (sample_valid && ctrl_r.op_mode),
    .sample  (sample),
    .busy    (reg_busy),
    .held_r  (held),
    .fresh_r (fresh)
  );

  // ==========================================================
  // access decode
  assign data_rd    = reg_rd && reg_addr >= `OFS_Y_LO && reg_addr <= `OFS_Z_HI;
  assign rel_rd     = reg_rd && reg_addr == `OFS_RELEASE;
  assign check_rd   = reg_rd && reg_addr == `OFS_CHECK;
  assign ready_set  = fresh && ctrl_r.ready_irq_en;
  assign motion_set = motion_event && ctrl_r.motion_en && ctrl_r.op_mode;
  // 14-bit only in full power with the top range code
  assign wide_mode  = ctrl_r.op_mode && ctrl_r.precision
                      && ctrl_r.range_sel == 2'b11;

  // ==========================================================
  // main control
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= '0;
    end else if (reg_wr && reg_addr == `OFS_MAINCTL) begin
      // no standby check: ordering is the host's duty
      ctrl_r.op_mode      <= reg_wdata[`B_OPMODE];
      ctrl_r.precision    <= reg_wdata[`B_PREC];
      ctrl_r.ready_irq_en <= reg_wdata[`B_DRIRQ];
      ctrl_r.range_sel    <= {reg_wdata[`B_RANGE_HI], reg_wdata[`B_RANGE_LO]};
      ctrl_r.motion_en    <= reg_wdata[`B_MOTION];
    end
  end
  assign ctrl = ctrl_r;

  // ==========================================================
  // interrupt sources; a set in the clear cycle wins
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_r <= 1'b0;
    end else if (ready_set) begin
      ready_r <= 1'b1;
    end else if (data_rd || rel_rd) begin
      ready_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      motion_r <= 1'b0;
    end else if (motion_set) begin
      motion_r <= 1'b1;
    end else if (rel_rd) begin
      motion_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_r <= 6'h00;
    end else if (motion_set) begin
      dir_r <= (rel_rd ? 6'h00 : dir_r) | motion_dir;
    end else if (rel_rd) begin
      dir_r <= 6'h00;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      summary_r <= 1'b0;
    end else if (ready_set || motion_set) begin
      summary_r <= 1'b1;
    end else if (data_rd || rel_rd) begin
      summary_r <= 1'b0;
    end
  end

  // ==========================================================
  // communication self-test
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      req_q_r <= 1'b0;
      armed_r <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      req_q_r <= selftest_req;
      done_r  <= check_rd && armed_r;
      // edge arming keeps a slow-to-clear trigger from re-arming
      if (selftest_req && !req_q_r) begin
        armed_r <= 1'b1;
      end else if (check_rd) begin
        armed_r <= 1'b0;
      end
    end
  end
  assign selftest_done = done_r;

  // ==========================================================
  // interrupt output
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_state_r <= accel_regs_pkg::IRQ_IDLE;
      pulse_cnt_r <= '0;
    end else begin
      unique case (irq_state_r)
        accel_regs_pkg::IRQ_IDLE: begin
          if (ready_set || motion_set) begin
            irq_state_r <= irq_pulse_select ? accel_regs_pkg::IRQ_PULSE
                                            : accel_regs_pkg::IRQ_HELD;
            pulse_cnt_r <= 32'(PULSE_CYC - 1);
          end
        end
        accel_regs_pkg::IRQ_PULSE: begin
          if (pulse_cnt_r == '0) begin
            irq_state_r <= accel_regs_pkg::IRQ_IDLE;
          end else begin
            pulse_cnt_r <= pulse_cnt_r - 32'd1;
          end
        end
        accel_regs_pkg::IRQ_HELD: begin
          if (rel_rd && !(ready_set || motion_set)) begin
            irq_state_r <= accel_regs_pkg::IRQ_IDLE;
          end
        end
      endcase
    end
  end
  assign irq_out = irq_state_r != accel_regs_pkg::IRQ_IDLE;

  // ==========================================================
  // read data
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      `OFS_Y_LO:    rd_mux = fmt_lo(held.y, ctrl_r.precision, wide_mode);
      `OFS_Y_HI:    rd_mux = fmt_hi(held.y);
      `OFS_Z_LO:    rd_mux = fmt_lo(held.z, ctrl_r.precision, wide_mode);
      `OFS_Z_HI:    rd_mux = fmt_hi(held.z);
      `OFS_CHECK:   rd_mux = armed_r ? `CHECK_ARMED : `CHECK_IDLE;
      `OFS_IDENT:   rd_mux = IDENT_CODE;
      `OFS_CAUSE: begin
        rd_mux[`B_CAUSE_SAMPLE_READY_FLAG] = ready_r;
        rd_mux[`B_CAUSE_MOT]  = motion_r;
      end
      `OFS_DIR:     rd_mux = {2'h0, dir_r};
      `OFS_SUMMARY: rd_mux[`B_SUMMARY] = summary_r;
      `OFS_MAINCTL: begin
        rd_mux[`B_OPMODE]   = ctrl_r.op_mode;
        rd_mux[`B_PREC]     = ctrl_r.precision;
        rd_mux[`B_DRIRQ]    = ctrl_r.ready_irq_en;
        rd_mux[`B_RANGE_HI] = ctrl_r.range_sel[1];
        rd_mux[`B_RANGE_LO] = ctrl_r.range_sel[0];
        rd_mux[`B_MOTION]   = ctrl_r.motion_en;
      end
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end
  end
  assign reg_rdata = rdata_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  check_resp_a: assert property (reg_rd && reg_addr == `OFS_CHECK |=>
    reg_rdata == ($past(armed_r) ? `CHECK_ARMED : `CHECK_IDLE))
    else $error("check response value wrong");
  check_clear_a: assert property (check_rd && !(selftest_req && !req_q_r) |=>
    !armed_r ##1 (rd_mux == `CHECK_IDLE || reg_addr != `OFS_CHECK || armed_r))
    else $error("self-test not cleared by read");
  release_clr_a: assert property (rel_rd && !ready_set && !motion_set |=>
    !ready_r && !motion_r && dir_r == 6'h00 && !summary_r)
    else $error("release read left a cause set");
  ready_set_a: assert property (ready_set |=> ready_r && summary_r)
    else $error("ready flag not set");
  motion_keep_a: assert property (motion_r && !rel_rd |=> motion_r)
    else $error("motion flag dropped without release");
  summary_or_a: assert property (summary_r |-> ready_r || motion_r ||
    $past(summary_r)) else $error("summary set without cause");
  held_irq_a: assert property (irq_state_r == accel_regs_pkg::IRQ_HELD && !rel_rd
    |=> irq_out) else $error("latched interrupt dropped");
  pulse_end_a: assert property (irq_state_r == accel_regs_pkg::IRQ_PULSE &&
    pulse_cnt_r == '0 |=> !irq_out) else $error("pulse too long");
  cause_res_a: assert property (reg_rd && reg_addr == `OFS_CAUSE |=>
    (reg_rdata & 8'hED) == 8'h00) else $error("reserved cause bits set");
  y_layout_a: assert property (reg_rd && reg_addr == `OFS_Y_LO |=>
    reg_rdata[3:0] == 4'h0 || $past(wide_mode)) else $error("low nibble not zero");

  // ==========================================================
  // read values, judged on the byte that the strobe edge loaded
  // $past because reg_rdata shows its byte one edge after the strobe
  z_layout_a: assert property (reg_rd && reg_addr == `OFS_Z_LO |=>
    reg_rdata[3:0] == 4'h0 || $past(wide_mode))
    else $error("z low nibble not zero");
  y_high_a: assert property (reg_rd && reg_addr == `OFS_Y_HI |=>
    reg_rdata == $past(held.y[13:6]))
    else $error("y high byte wrong");
  z_high_a: assert property (reg_rd && reg_addr == `OFS_Z_HI |=>
    reg_rdata == $past(held.z[13:6]))
    else $error("z high byte wrong");
  low_narrow_a: assert property (!ctrl_r.precision && reg_rd &&
    reg_addr == `OFS_Y_LO |=> reg_rdata == 8'h00)
    else $error("8-bit low byte not zero");
  ident_read_a: assert property (reg_rd && reg_addr == `OFS_IDENT |=>
    reg_rdata == IDENT_CODE)
    else $error("identity byte wrong");
  dir_reserved_a: assert property (reg_rd && reg_addr == `OFS_DIR |=>
    reg_rdata[7:6] == 2'h0)
    else $error("direction top bits set");
  summary_reserved_a: assert property (reg_rd && reg_addr == `OFS_SUMMARY |=>
    (reg_rdata & 8'hEF) == 8'h00)
    else $error("summary reserved bits set");
  ctrl_reserved_a: assert property (reg_rd && reg_addr == `OFS_MAINCTL |=>
    (reg_rdata & 8'h05) == 8'h00)
    else $error("control reserved bits set");

  // ==========================================================
  // causes, enables, interrupt output, sample hold and self-test arming
  // enables are judged one edge back, where the set was decided
  read_hold_a: assert property (reg_busy |=>
    $stable(held))
    else $error("sample changed during a read");
  ready_enable_a: assert property ($rose(ready_r) |->
    $past(ctrl_r.ready_irq_en))
    else $error("ready flag set while disabled");
  motion_enable_a: assert property ($rose(motion_r) |->
    $past(ctrl_r.motion_en && ctrl_r.op_mode))
    else $error("motion flag set while disabled");
  wide_standby_a: assert property (!ctrl_r.op_mode |->
    !wide_mode)
    else $error("14-bit mode in standby");
  release_irq_a: assert property (irq_state_r == accel_regs_pkg::IRQ_HELD && rel_rd
    && !ready_set && !motion_set |=> !irq_out)
    else $error("release read left interrupt up");
  dir_latch_a: assert property (dir_r != 6'h00 && !rel_rd |=>
    dir_r != 6'h00)
    else $error("direction dropped without release");
  pulse_length_a: assert property (irq_state_r == accel_regs_pkg::IRQ_PULSE |->
    pulse_cnt_r < 32'(PULSE_CYC))
    else $error("pulse counter out of range");
  check_arm_a: assert property ($rose(armed_r) |->
    $past(selftest_req))
    else $error("self-test armed without trigger");

  ready_cov: cover property (ready_set ##[1:20] data_rd);
  motion_cov: cover property (motion_set ##[1:20] rel_rd);
  selftest_cov: cover property (armed_r ##[1:20] check_rd);
  pulse_cov: cover property (irq_state_r == accel_regs_pkg::IRQ_PULSE ##1 !irq_out);
  defer_cov: cover property (reg_busy && sample_valid && ctrl_r.op_mode ##[1:20] fresh);
endmodule // accel_output_interrupt_regs

// >>> accel_host_model.sv
// host-side model of the byte register port that faces the register bank
// assumes the bank takes strobes on rising mclk and loads read data at that edge
`timescale 1ns/1ns
module accel_host_model (
  input  wire logic mclk,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_wdata,
  output logic       reg_busy,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    reg_busy = 1'b0;
  end
  // ==========================================================
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // released data line shows no stale value
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    reg_busy = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    d = reg_rdata;
    reg_busy = 1'b0;
  endtask
  // control fields only change from standby
  task automatic set_ctrl(input logic [7:0] v);
    wr(8'h1B, v & 8'h7F);
    wr(8'h1B, v);
  endtask
endmodule // accel_host_model

// >>> accel_output_interrupt_regs_bench.sv
// self-checking bench for the output, interrupt and main control registers
// assumes the host model drives the register port, bench drives the sensing side
`timescale 1ns/1ns
module accel_output_interrupt_regs_bench;
  localparam int         P  = 4;
  localparam logic [7:0] ID = 8'h3C; // arbitrary value
  logic mclk, sys_rst, sample_valid, motion_event, selftest_req, irq_pulse_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, v;
  logic       reg_wr, reg_rd, reg_busy, selftest_done, irq_out, wide_mode;
  logic [5:0] motion_dir;
  accel_regs_pkg::sample_pair_t sample, s;
  accel_regs_pkg::main_ctrl_t   ctrl;
  int fail_count, n_compared, n_done, hi_cnt, seed;
  accel_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_busy(reg_busy), .reg_rdata(reg_rdata));
  accel_output_interrupt_regs #(.PULSE_CYC(P), .IDENT_CODE(ID)) dut (.mclk(mclk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_busy(reg_busy), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample(sample), .motion_event(motion_event),
    .motion_dir(motion_dir), .selftest_req(selftest_req),
    .irq_pulse_select(irq_pulse_select), .selftest_done(selftest_done),
    .irq_out(irq_out), .ctrl(ctrl), .wide_mode(wide_mode));
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if (selftest_done === 1'b1) n_done++;
    if (irq_out === 1'b1) hi_cnt++;
  end
  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] lo_exp(input logic [13:0] x, input logic [7:0] c);
    if (!c[6]) return 8'h00;
    if (c[4:3] == 2'b11) return {x[5:0], 2'b00};
    return {x[5:2], 4'h0};
  endfunction
  task automatic load(input accel_regs_pkg::sample_pair_t x);
    @(negedge mclk);
    sample = x;
    sample_valid = 1'b1;
    @(negedge mclk);
    sample_valid = 1'b0;
    sample = ~x;
    repeat (2) @(negedge mclk);
  endtask
  task automatic test_done;
    $display("fail_count=%0d n_compared=%0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    test_done;
  end
  // ==========================================================
  // scenarios
  initial begin
    {mclk, sample_valid, motion_event, selftest_req, irq_pulse_select} = 5'h00;
    {motion_dir, sample, fail_count, n_compared, n_done, hi_cnt} = '0;
    sys_rst = 1'b1;
    seed = $urandom(40183);
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    host.rd(8'h1B, d); chk(d, 8'h00);
    host.rd(8'h0C, d); chk(d, 8'h55);
    host.wr(8'h0F, 8'hFF);
    host.rd(8'h0F, d); chk(d, ID);
    host.rd(8'h00, d); chk(d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      host.set_ctrl(v);
      host.rd(8'h1B, d); chk(d, v & 8'hFA);
      chk({2'b00, ctrl}, {2'b00, v[7:3], v[1]});
      chk({7'h0, wide_mode}, {7'h0, v[7] & v[6] & (v[4:3] == 2'b11)});
    end
    // 8-bit, 12-bit and 14-bit layouts
    for (int m = 0; m < 3; m++) begin
      v = (m == 0) ? 8'hA8 : (m == 1) ? 8'hE8 : 8'hF8;
      host.set_ctrl(v);
      s = accel_regs_pkg::sample_pair_t'(28'($urandom));
      load(s);
      chk({7'h0, irq_out}, 8'h01);
      host.rd(8'h16, d); chk(d, 8'h10);
      host.rd(8'h18, d); chk(d, 8'h10);
      host.rd(8'h08, d); chk(d, lo_exp(s.y, v));
      host.rd(8'h09, d); chk(d, s.y[13:6]);
      host.rd(8'h0A, d); chk(d, lo_exp(s.z, v));
      host.rd(8'h0B, d); chk(d, s.z[13:6]);
      host.rd(8'h16, d); chk(d, 8'h00);
      host.rd(8'h18, d); chk(d, 8'h00);
      chk({7'h0, irq_out}, 8'h01);
      host.rd(8'h1A, d);
      chk({7'h0, irq_out}, 8'h00);
    end
    // motion latched until release
    motion_dir = 6'($urandom_range(1, 63));
    host.set_ctrl(8'h80);
    @(negedge mclk) motion_event = 1'b1;
    @(negedge mclk) motion_event = 1'b0;
    host.rd(8'h16, d); chk(d, 8'h00);
    host.set_ctrl(8'h82);
    @(negedge mclk) motion_event = 1'b1;
    @(negedge mclk) motion_event = 1'b0;
    repeat (2) @(negedge mclk);
    chk({7'h0, irq_out}, 8'h01);
    host.rd(8'h16, d); chk(d, 8'h02);
    host.rd(8'h17, d); chk(d, {2'b00, motion_dir});
    host.rd(8'h18, d); chk(d, 8'h10);
    host.rd(8'h08, d);
    host.rd(8'h16, d); chk(d, 8'h02);
    host.rd(8'h1A, d);
    host.rd(8'h16, d); chk(d, 8'h00);
    host.rd(8'h17, d); chk(d, 8'h00);
    chk({7'h0, irq_out}, 8'h00);
    // ready ignored in standby or with its enable clear
    host.set_ctrl(8'h20);
    load(s);
    host.rd(8'h16, d); chk(d, 8'h00);
    host.set_ctrl(8'h80);
    load(s);
    host.rd(8'h16, d); chk(d, 8'h00);
    chk({7'h0, irq_out}, 8'h00);
    // a sample landing mid-read waits until the read ends
    fork
      host.rd(8'h09, d);
      load(~s);
    join
    chk(d, s.y[13:6]);
    host.rd(8'h09, d); chk(d, ~s.y[13:6]);
    // self-test response
    @(negedge mclk) selftest_req = 1'b1;
    repeat (2) @(negedge mclk);
    host.rd(8'h0C, d); chk(d, 8'hAA);
    chk(8'(n_done), 8'h01);
    selftest_req = 1'b0;
    host.rd(8'h0C, d); chk(d, 8'h55);
    chk(8'(n_done), 8'h01);
    // pulse response stands exactly PULSE_CYC cycles
    irq_pulse_select = 1'b1;
    host.set_ctrl(8'hA0);
    hi_cnt = 0;
    load(s);
    repeat (20) @(negedge mclk);
    chk(8'(hi_cnt), 8'(P));
    host.rd(8'h1A, d);
    test_done;
  end
endmodule // accel_output_interrupt_regs_bench
